// ==== rtl/csc_pkg.sv ====
// Shared constants and types for the configuration and security command controller.
package csc_pkg;

  // ------------------------------------------------------------------
  // Command space
  // ------------------------------------------------------------------
  localparam int unsigned CMD_W          = 7;
  localparam int unsigned DATA_W         = 8;
  localparam logic [6:0]  CMD_SUB_LO     = 7'h3E;
  localparam logic [6:0]  CMD_SUB_HI     = 7'h3F;
  localparam logic [6:0]  CMD_BLOCK      = 7'h40;
  localparam logic [6:0]  CMD_SETTING    = 7'h10;
  localparam logic [6:0]  CMD_STATUS     = 7'h00;
  localparam logic [6:0]  CMD_LEVEL      = 7'h01;
  localparam logic [6:0]  CMD_SIGNATURE  = 7'h02;

  // ------------------------------------------------------------------
  // Subcommands, 16-bit codes
  // ------------------------------------------------------------------
  localparam logic [15:0] SUB_KEY          = 16'h0035;
  localparam logic [15:0] SUB_LOCK         = 16'h0030;
  localparam logic [15:0] SUB_CFG_ENTER    = 16'h0090;
  localparam logic [15:0] SUB_CFG_EXIT     = 16'h0092;
  localparam logic [15:0] SUB_IROM_SIG     = 16'h0009;
  localparam logic [15:0] SUB_DROM_SIG     = 16'h000A;
  localparam logic [15:0] SUB_CFG_SIG      = 16'h000B;
  localparam logic [15:0] SUB_SCRATCH      = 16'h0070;
  localparam logic [15:0] SUB_OTP_COMMIT   = 16'h00A0;
  localparam logic [15:0] SUB_DM_ACCESS    = 16'h0071;

  // ------------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------------
  localparam int unsigned SCRATCH_BYTES  = 32;
  localparam int unsigned CFG_WORDS      = 8;
  localparam int unsigned LIVE_WORDS     = 2;
  localparam logic [7:0]  CFG_DEFAULT    = 8'h00;
  localparam logic [15:0] SIG_SEED       = 16'hFFFF;
  localparam logic [15:0] SIG_POLY       = 16'h1021;

  // Default keys; values are arbitrary.
  localparam logic [31:0] KEY_UNLOCK     = 32'h1234_5678;
  localparam logic [31:0] KEY_FULL       = 32'hABCD_EF01;

  // Status byte fields.
  localparam int unsigned ST_LEVEL_LSB   = 0;
  localparam int unsigned ST_HALT_BIT    = 2;
  localparam int unsigned ST_MISM_BIT    = 3;
  localparam int unsigned ST_DIAG_BIT    = 4;
  localparam int unsigned ST_READY_BIT   = 5;

  typedef enum logic [1:0] {
    CSC_LOCKED, CSC_INTERMEDIATE, CSC_FULL
  } csc_level_t;

  typedef enum logic [1:0] {
    CSC_PWR_NORMAL, CSC_PWR_SLEEP, CSC_PWR_RETAIN, CSC_PWR_OFF
  } csc_power_t;

endpackage

// ==== rtl/csc_link_if.sv ====
// Link between host controller and device command controller.
`timescale 1ns/1ns
`default_nettype none
interface csc_link_if;
  logic       req;
  logic       wr;
  logic [6:0] cmd;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport dev  (input req, input wr, input cmd, input wdata, output ack, output rdata);
  modport host (output req, output wr, output cmd, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// ==== rtl/csc_device.sv ====
// Device end: command decode, settings load, security levels and checks.
// Operation
// R1: 7-bit direct codes act, write or read.
// R2: Subcommands through code pair, block transfers.
// R3: Power-up copies OTP into RAM settings.
// R4: Host rewrites settings if OTP unused.
// R5: Settings kept across normal, sleep, retaining.
// R6: Off state clears; reload defaults or OTP.
// R7: Locked: reads, subset writes, no memory.
// R8: Intermediate adds subcommands and memory access.
// R9: Full privilege modifies all, programs OTP.
// R10: Halt mode stops, restarts with settings.
// R11: Halt entry only at full privilege.
// R12: Level changes need correct key set.
// R13: ROM signatures computed and returned.
// R14: Config signature compared, mismatch flagged.
// R15: Scratchpad readable always, writable full only.
// R16: Live subset writable while operating.
// R17: Integrity checks and diagnostics monitored.
// R18: Wrong keys leave level unchanged.
// R19: Forbidden writes ignored without effect.
`timescale 1ns/1ns
`default_nettype none
module csc_device #(
  parameter logic [31:0] UNLOCK_KEY = csc_pkg::KEY_UNLOCK,
  parameter logic [31:0] FULL_KEY   = csc_pkg::KEY_FULL
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  csc_link_if.dev                   link,
  input  wire csc_pkg::csc_power_t  power_state,
  input  wire logic                 otp_valid,
  input  wire logic [7:0]           otp_cfg_byte,
  output logic [2:0]                otp_addr,
  output logic                      otp_prog,
  output logic [7:0]                otp_prog_data,
  input  wire logic [15:0]          irom_word,
  input  wire logic [15:0]          drom_word,
  input  wire logic                 ref_mismatch,
  input  wire logic                 lfo_fault,
  input  wire logic                 wdog_fault,
  output logic                      halted,
  output logic                      diag_fault,
  output logic [1:0]                level
);
  import csc_pkg::*;

  typedef struct packed {
    csc_level_t                 lvl;
    logic                       halt;
    logic                       loading;
    logic [2:0]                 ld_idx;
    logic [15:0]                sub;
    logic [31:0]                key;
    logic [1:0]                 key_cnt;
    logic [4:0]                 blk_ptr;
    logic [15:0]                sig;
    logic [15:0]                cfg_sig;
    logic [15:0]                stored_sig;
    logic                       mism;
    logic                       diag;
    logic                       ack;
    logic [7:0]                 rdata;
    logic                       prog;
    logic [7:0]                 pdata;
    logic [CFG_WORDS*8-1:0]     cfg;
    logic [SCRATCH_BYTES*8-1:0] scr;
  } csc_dev_state_t;

  csc_dev_state_t st;
  csc_dev_state_t next_st;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c ^ d;
    for (int i = 0; i < 16; i++) begin
      r = r[15] ? ((r << 1) ^ SIG_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic sub_allowed(input logic [15:0] s, input csc_level_t l);
    if (s == SUB_KEY || s == SUB_LOCK || s == SUB_IROM_SIG || s == SUB_DROM_SIG) begin
      return 1'b1;
    end else if (s == SUB_SCRATCH || s == SUB_CFG_SIG) begin
      return 1'b1;
    end else if (s == SUB_DM_ACCESS) begin
      return l != CSC_LOCKED;
    end else begin
      return l == CSC_FULL;
    end
  endfunction

  logic [15:0] cfg_crc;

  // ------------------------------------------------------------------
  // Configuration signature over static settings
  // ------------------------------------------------------------------
  // R14: static data signature
  always_comb begin
    cfg_crc = SIG_SEED;
    for (int i = LIVE_WORDS; i < CFG_WORDS; i++) begin
      cfg_crc = crc_step(cfg_crc, {8'h00, st.cfg[i*8 +: 8]});
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.ack  = 1'b0;
    next_st.prog = 1'b0;
    // R17: diagnostics latch
    if (ref_mismatch || lfo_fault || wdog_fault) begin
      next_st.diag = 1'b1;
    end
    // R6: off state clears memory
    if (power_state == CSC_PWR_OFF) begin
      next_st.cfg     = '0;
      next_st.scr     = '0;
      next_st.lvl     = CSC_LOCKED;
      next_st.halt    = 1'b0;
      next_st.loading = 1'b1;
      next_st.ld_idx  = '0;
      next_st.stored_sig = SIG_SEED;
    end else if (st.loading) begin
      // R3: copy OTP into settings
      next_st.cfg[st.ld_idx*8 +: 8] = otp_valid ? otp_cfg_byte : CFG_DEFAULT;
      // R17: power-up memory check
      if (st.ld_idx >= 3'(LIVE_WORDS)) begin
        next_st.stored_sig = crc_step(st.stored_sig,
                                      {8'h00, otp_valid ? otp_cfg_byte : CFG_DEFAULT});
      end
      next_st.ld_idx     = st.ld_idx + 3'd1;
      if (st.ld_idx == 3'(CFG_WORDS - 1)) begin
        next_st.loading = 1'b0;
      end
    end else if (link.req && !st.ack) begin
      // R5: retained states keep settings
      next_st.ack = 1'b1;
      if (link.wr) begin
        // R1: direct write codes
        if (link.cmd == CMD_SUB_LO) begin
          // R2: subcommand low byte
          next_st.sub[7:0] = link.wdata;
          next_st.blk_ptr  = '0;
        end else if (link.cmd == CMD_SUB_HI) begin
          next_st.sub[15:8] = link.wdata;
          next_st.sig       = SIG_SEED;
          if ({link.wdata, st.sub[7:0]} == SUB_LOCK) begin
            next_st.lvl = CSC_LOCKED;
          end else if ({link.wdata, st.sub[7:0]} == SUB_CFG_ENTER) begin
            // R11: halt entry needs full privilege
            if (st.lvl == CSC_FULL) begin
              next_st.halt = 1'b1;
            end
          end else if ({link.wdata, st.sub[7:0]} == SUB_CFG_EXIT) begin
            // R10: restart with new settings
            next_st.halt = 1'b0;
          end else if ({link.wdata, st.sub[7:0]} == SUB_CFG_SIG) begin
            next_st.cfg_sig = cfg_crc;
            next_st.mism    = cfg_crc != st.stored_sig;
          end else if ({link.wdata, st.sub[7:0]} == SUB_KEY) begin
            next_st.key_cnt = '0;
          end
        end else if (link.cmd >= CMD_BLOCK && sub_allowed(st.sub, st.lvl)) begin
          // R2: block write into subcommand buffer
          next_st.blk_ptr = st.blk_ptr + 5'd1;
          if (st.sub == SUB_KEY) begin
            next_st.key = {st.key[23:0], link.wdata};
            next_st.key_cnt = st.key_cnt + 2'd1;
            // R12: key set changes level
            if (st.key_cnt == 2'd3) begin
              if ({st.key[23:0], link.wdata} == UNLOCK_KEY && st.lvl == CSC_LOCKED) begin
                next_st.lvl = CSC_INTERMEDIATE;
              end else if ({st.key[23:0], link.wdata} == FULL_KEY
                           && st.lvl == CSC_INTERMEDIATE) begin
                next_st.lvl = CSC_FULL;
              end
              // R18: bad keys leave level unchanged
            end
          end else if (st.sub == SUB_SCRATCH && st.lvl == CSC_FULL) begin
            // R15: scratchpad write at full only
            next_st.scr[st.blk_ptr*8 +: 8] = link.wdata;
          end else if (st.sub == SUB_DM_ACCESS) begin
            // R8: intermediate writes data memory
            if (st.halt || st.lvl == CSC_FULL || st.blk_ptr >= 5'(LIVE_WORDS)) begin
              if (st.blk_ptr < 5'(CFG_WORDS)) begin
                next_st.cfg[st.blk_ptr[2:0]*8 +: 8] = link.wdata;
              end
            end
          end else if (st.sub == SUB_OTP_COMMIT && st.lvl == CSC_FULL) begin
            // R9: full privilege programs OTP
            next_st.prog  = 1'b1;
            next_st.pdata = st.scr[st.blk_ptr*8 +: 8];
          end
        end else if (link.cmd >= CMD_SETTING && link.cmd < CMD_SETTING + 7'(LIVE_WORDS)) begin
          // R16: live subset writable at any level
          next_st.cfg[link.cmd[0]*8 +: 8] = link.wdata;
        end
        // R7: other writes refused when locked
        // R19: refused writes leave state
      end else begin
        if (link.cmd == CMD_STATUS) begin
          next_st.rdata = {2'b00, 1'b1, st.diag, st.mism, st.halt, st.lvl};
        end else if (link.cmd == CMD_LEVEL) begin
          next_st.rdata = {6'd0, st.lvl};
        end else if (link.cmd >= CMD_BLOCK && sub_allowed(st.sub, st.lvl)) begin
          next_st.blk_ptr = st.blk_ptr + 5'd1;
          if (st.sub == SUB_SCRATCH) begin
            next_st.rdata = st.scr[st.blk_ptr*8 +: 8];
          end else if (st.sub == SUB_IROM_SIG || st.sub == SUB_DROM_SIG) begin
            // R13: ROM signature readback
            next_st.sig   = crc_step(st.sig, st.sub == SUB_IROM_SIG ? irom_word : drom_word);
            next_st.rdata = st.blk_ptr[0] ? st.sig[15:8] : st.sig[7:0];
          end else if (st.sub == SUB_CFG_SIG) begin
            next_st.rdata = st.blk_ptr[0] ? {7'd0, st.mism} : st.cfg_sig[7:0];
          end else if (st.sub == SUB_DM_ACCESS && st.blk_ptr < 5'(CFG_WORDS)) begin
            next_st.rdata = st.cfg[st.blk_ptr[2:0]*8 +: 8];
          end else begin
            next_st.rdata = 8'h00;
          end
        end else if (link.cmd >= CMD_SETTING && link.cmd < CMD_SETTING + 7'(LIVE_WORDS)) begin
          next_st.rdata = st.cfg[link.cmd[0]*8 +: 8];
        end else begin
          next_st.rdata = 8'h00;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.loading    <= 1'b1;
      st.sig        <= SIG_SEED;
      st.stored_sig <= SIG_SEED;
    end else begin
      st <= next_st;
    end
  end

  assign link.ack      = st.ack;
  assign link.rdata    = st.rdata;
  assign otp_addr      = st.ld_idx;
  assign otp_prog      = st.prog;
  assign otp_prog_data = st.pdata;
  assign halted        = st.halt;
  assign diag_fault    = st.diag;
  assign level         = st.lvl;
endmodule
`default_nettype wire

// ==== rtl/csc_host.sv ====
// Host end: issues one command byte transfer per user request.
`timescale 1ns/1ns
`default_nettype none
module csc_host (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  csc_link_if.host        link,
  input  wire logic       user_go,
  input  wire logic       user_wr,
  input  wire logic [6:0] user_cmd,
  input  wire logic [7:0] user_wdata,
  output logic            user_busy,
  output logic            user_done,
  output logic [7:0]      user_rdata
);
  import csc_pkg::*;

  typedef struct packed {
    logic       busy;
    logic       wr;
    logic [6:0] cmd;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;
  } csc_host_state_t;

  csc_host_state_t st;
  csc_host_state_t next_st;

  // ------------------------------------------------------------------
  // Request sequencing
  // ------------------------------------------------------------------
  // R1: one code per transfer
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!st.busy && user_go) begin
      next_st.busy  = 1'b1;
      next_st.wr    = user_wr;
      next_st.cmd   = user_cmd;
      next_st.wdata = user_wdata;
    end else if (st.busy && link.ack) begin
      next_st.busy  = 1'b0;
      next_st.done  = 1'b1;
      next_st.rdata = link.rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // R4: host program rewrites settings
  assign link.req   = st.busy && !link.ack;
  assign link.wr    = st.wr;
  assign link.cmd   = st.cmd;
  assign link.wdata = st.wdata;
  assign user_busy  = st.busy;
  assign user_done  = st.done;
  assign user_rdata = st.rdata;
endmodule
`default_nettype wire

// ==== bench/csc_link_chk.sv ====
// Protocol checker for the link between the host and device ends.
`timescale 1ns/1ns
`default_nettype none
module csc_link_chk (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [6:0] cmd,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  import csc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ack_one_cycle_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_has_req_a: assert property (ack |-> $past(req))
    else $error("ack without a request");
  req_drops_a: assert property (ack |-> !req)
    else $error("request still high with ack");
  req_held_a: assert property (req && !ack |=> $stable(cmd) && $stable(wr) && $stable(wdata))
    else $error("request changed before ack");
  ack_in_time_a: assert property ($rose(req) |-> ##[1:20] ack)
    else $error("request not answered in time");
  rdata_on_read_a: assert property ($changed(rdata) |-> ack && !$past(wr))
    else $error("read data changed outside a read");
  status_ready_a: assert property (ack && !$past(wr) && $past(cmd) == CMD_STATUS
    |-> rdata[7:5] == 3'h1)
    else $error("status upper bits wrong");
  level_range_a: assert property (ack && !$past(wr) && $past(cmd) == CMD_LEVEL
    |-> rdata[7:2] == 6'h00 && rdata[1:0] != 2'h3)
    else $error("level read out of range");
  cover property (ack && $past(wr));
  cover property (ack && !$past(wr) && $past(cmd) == CMD_STATUS);
  cover property (ack && !$past(wr) && $past(cmd) == CMD_BLOCK);
endmodule
`default_nettype wire

// ==== bench/test_config_security_command_ctrl.sv ====
// Self-checking bench: host end and device end joined by the link.
`timescale 1ns/1ns
`default_nettype none
module test_config_security_command_ctrl;
  import csc_pkg::*;
  logic       ref_clk = 1'h0;
  logic       rst_b = 1'h0;
  csc_power_t power_state = CSC_PWR_NORMAL;
  logic       otp_valid = 1'h1;
  logic [7:0] otp_mem [8];
  wire  [2:0] otp_addr;
  wire  [7:0] otp_cfg_byte = otp_mem[otp_addr];
  logic [15:0] irom_word = 16'h0000;
  logic [15:0] drom_word = 16'h0000;
  logic       ref_mismatch = 1'h0;
  logic       lfo_fault = 1'h0;
  logic       wdog_fault = 1'h0;
  logic       user_go = 1'h0;
  logic       user_wr = 1'h0;
  logic [6:0] user_cmd = 7'h00;
  logic [7:0] user_wdata = 8'h00;
  wire        user_busy, user_done, halted, diag_fault;
  wire  [7:0] user_rdata;
  wire  [1:0] level;
  logic [31:0] seed = 32'hb052_df27;
  logic [15:0] crc;
  logic [7:0] rd, m_set, m_scr;
  logic [1:0] m_lvl;
  wire        otp_prog;
  wire  [7:0] otp_prog_data;
  logic [7:0] v, prog_byte;
  logic [7:0] prog_cnt = 8'h00;
  logic       m_halt, m_diag;
  int         err_count = 0;
  int         n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  csc_link_if link ();
  csc_device i_csc_device (.ref_clk, .rst_b, .link(link), .power_state, .otp_valid,
    .otp_cfg_byte, .otp_addr, .otp_prog, .otp_prog_data, .irom_word, .drom_word,
    .ref_mismatch, .lfo_fault, .wdog_fault, .halted, .diag_fault, .level);
  csc_host i_csc_host (.ref_clk, .rst_b, .link(link), .user_go, .user_wr, .user_cmd,
    .user_wdata, .user_busy, .user_done, .user_rdata);
  csc_link_chk i_csc_link_chk (.ref_clk, .rst_b, .req(link.req), .wr(link.wr),
    .cmd(link.cmd), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Bit-serial signature model, one 16-bit word per call.
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int b = 15; b >= 0; b--) r = {r[14:0], 1'h0} ^ ((r[15] ^ w[b]) ? SIG_POLY : 16'h0000);
    return r;
  endfunction
  // Counts programming pulses and keeps the last programmed byte.
  always @(posedge ref_clk) begin
    if (otp_prog === 1'h1) begin
      prog_cnt <= prog_cnt + 8'h01;
      prog_byte <= otp_prog_data;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [6:0] c, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    user_go <= 1'h1;
    user_wr <= w;
    user_cmd <= c;
    user_wdata <= d;
    @(posedge ref_clk);
    user_go <= 1'h0;
    for (i = 0; i < 20 && user_done !== 1'h1; i++) @(posedge ref_clk);
    if (i == 20) begin
      err_count++;
      conclude();
    end
    rd = user_rdata;
  endtask
  task automatic sub(input logic [15:0] c);
    xfer(1'h1, CMD_SUB_LO, c[7:0]);
    xfer(1'h1, CMD_SUB_HI, c[15:8]);
  endtask
  // Key bytes go most significant first after the key subcommand.
  task automatic key(input logic [31:0] k);
    sub(SUB_KEY);
    for (int i = 0; i < 4; i++) xfer(1'h1, CMD_BLOCK, k[31 - 8 * i -: 8]);
  endtask
  task automatic look();
    xfer(1'h0, CMD_LEVEL, 8'h00);
    check("level read", rd, {6'h00, m_lvl});
    check("level pin", {6'h00, level}, {6'h00, m_lvl});
    check("halted", {7'h00, halted}, {7'h00, m_halt});
    check("diag pin", {7'h00, diag_fault}, {7'h00, m_diag});
    check("busy", {7'h00, user_busy}, 8'h00);
    xfer(1'h0, CMD_STATUS, 8'h00);
    check("status", rd & 8'hf7, {3'h1, m_diag, 1'h0, m_halt, m_lvl});
    xfer(1'h0, CMD_SETTING, 8'h00);
    check("setting", rd, m_set);
  endtask
  task automatic scratch(input logic [7:0] v);
    sub(SUB_SCRATCH);
    xfer(1'h1, CMD_BLOCK, v);
    if (m_lvl == CSC_FULL) m_scr = v;
    sub(SUB_SCRATCH);
    xfer(1'h0, CMD_BLOCK, 8'h00);
    check("scratch", rd, m_scr);
  endtask
  // Each block read returns the signature so far, then folds in one ROM word.
  task automatic sig(input logic [15:0] c, input logic [15:0] w);
    crc = SIG_SEED;
    sub(c);
    for (int r = 0; r < 4; r++) begin
      xfer(1'h0, CMD_BLOCK, 8'h00);
      check("signature", rd, (r % 2 == 0) ? crc[7:0] : crc[15:8]);
      crc = crc16(crc, w);
    end
  endtask
  // Static settings are byte 2 set to b2 and bytes 3 to 7 cleared.
  task automatic cfg_sig(input logic [7:0] b2, input logic [7:0] mm);
    crc = crc16(SIG_SEED, {8'h00, b2});
    for (int b = 0; b < 5; b++) crc = crc16(crc, 16'h0000);
    sub(SUB_CFG_SIG);
    xfer(1'h0, CMD_BLOCK, 8'h00);
    check("config signature", rd, crc[7:0]);
    xfer(1'h0, CMD_BLOCK, 8'h00);
    check("config mismatch", rd, mm);
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      otp_mem[i] = seed[7:0];
    end
    irom_word = seed[31:16];
    drom_word = seed[23:8];
    m_set = otp_mem[0];
    m_scr = 8'h00;
    m_lvl = CSC_LOCKED;
    m_halt = 1'h0;
    m_diag = 1'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'h1;
    repeat (10) @(posedge ref_clk);
    look();
    seed = xs(seed);
    m_set = seed[7:0];
    xfer(1'h1, CMD_SETTING, m_set);
    sub(SUB_CFG_ENTER);
    look();
    scratch(seed[15:8]);
    key(KEY_FULL);
    look();
    key(KEY_UNLOCK ^ seed);
    look();
    key(KEY_UNLOCK);
    m_lvl = CSC_INTERMEDIATE;
    sub(SUB_CFG_ENTER);
    look();
    scratch(seed[23:16]);
    key(KEY_FULL);
    m_lvl = CSC_FULL;
    scratch(seed[31:24]);
    sub(SUB_CFG_ENTER);
    m_halt = 1'h1;
    m_set = seed[15:8];
    xfer(1'h1, CMD_SETTING, m_set);
    look();
    sub(SUB_CFG_EXIT);
    m_halt = 1'h0;
    look();
    sig(SUB_IROM_SIG, irom_word);
    sig(SUB_DROM_SIG, drom_word);
    @(posedge ref_clk);
    lfo_fault <= 1'h1;
    @(posedge ref_clk);
    lfo_fault <= 1'h0;
    m_diag = 1'h1;
    look();
    for (int p = 1; p < 4; p++) begin
      @(posedge ref_clk);
      power_state <= csc_power_t'(p);
      otp_valid <= (p != 3);
      repeat (3) @(posedge ref_clk);
      power_state <= CSC_PWR_NORMAL;
      repeat (10) @(posedge ref_clk);
      if (p == 3) begin
        m_lvl = CSC_LOCKED;
        m_set = CFG_DEFAULT;
        m_scr = 8'h00;
      end
      look();
    end
    m_set = seed[23:16];
    xfer(1'h1, CMD_SETTING, m_set);
    look();
    cfg_sig(8'h00, 8'h00);
    key(KEY_UNLOCK);
    key(KEY_FULL);
    m_lvl = CSC_FULL;
    v = seed[7:0] | 8'h01;
    sub(SUB_DM_ACCESS);
    xfer(1'h1, CMD_BLOCK, m_set);
    xfer(1'h1, CMD_BLOCK, 8'h00);
    xfer(1'h1, CMD_BLOCK, v);
    cfg_sig(v, 8'h01);
    sub(SUB_DM_ACCESS);
    for (int b = 0; b < 3; b++) begin
      xfer(1'h0, CMD_BLOCK, 8'h00);
      check("data memory", rd, b == 2 ? v : (b == 0 ? m_set : 8'h00));
    end
    scratch(v);
    sub(SUB_OTP_COMMIT);
    xfer(1'h1, CMD_BLOCK, 8'h00);
    check("program count", prog_cnt, 8'h01);
    check("program data", prog_byte, v);
    sub(SUB_LOCK);
    m_lvl = CSC_LOCKED;
    sub(SUB_DM_ACCESS);
    xfer(1'h1, CMD_BLOCK, ~m_set);
    look();
    sub(SUB_DM_ACCESS);
    xfer(1'h0, CMD_BLOCK, 8'h00);
    check("locked memory read", rd, 8'h00);
    sub(SUB_OTP_COMMIT);
    xfer(1'h1, CMD_BLOCK, 8'h00);
    check("program refused", prog_cnt, 8'h01);
    scratch(8'h00);
    conclude();
  end
endmodule
`default_nettype wire
